/* rtl/pml_link.sv */
// Protocol multiplex link layer: transmit scheduling and receive steering
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Multiplexing off after reset; no mux packet sent until enabled.
// - While disabled, arriving mux packets are discarded unseen.
// - Enable is held per Link, independent of other Links.
// - Up to four mux channels, each with a software-chosen protocol.
// - TLPs and mux packets share the Link, interleaved both ways.
// - TLP and DLLP format and handling unchanged by multiplexing.
// - Mux traffic never touches native sequence numbers or credits.
// - Every transmitted mux packet carries a trailing LCRC.
// - Mux LCRC uses a seed different from the TLP seed.
// - No ack, nak or replay for mux packets.
// - Sequence number position carries a 12-bit metadata field.
// - Transmit scheduler chooses among mux packets, TLPs and DLLPs.
// - Arbitration and encapsulation sit between queues and the Link.
// - Receiver classifies, decapsulates and steers to matching queue.
// - Physical framing marks mux packets apart from TLPs.
// - Mux packets go to and come from a protocol upper layer.
// - No addressing or routing applied to mux packets.
// - Unsupported link speed disables every mux channel.
// - FLR to upstream function 0 disables all channels; others do not.
module pml_link #(
    parameter int NUM_CHAN = pml_pkg::NUM_CHAN,
    parameter logic [31:0] MUX_SEED = pml_pkg::MUX_SEED,
    parameter bit IS_UPSTREAM = 1'b1
) (
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic i_mux_enable,
    input wire logic [NUM_CHAN-1:0] i_chan_enable,
    input wire logic [NUM_CHAN-1:0][pml_pkg::PROTO_W-1:0] i_chan_proto,
    input wire logic i_speed_supported,
    input wire logic i_dl_down,
    input wire logic i_flr,
    input wire logic [pml_pkg::FUNC_W-1:0] i_flr_func,
    input wire pml_pkg::pml_word_s i_tx_tlp,
    output logic o_tx_tlp_ready,
    input wire pml_pkg::pml_word_s i_tx_dllp,
    output logic o_tx_dllp_ready,
    input wire pml_pkg::pml_mux_tx_s i_tx_mux,
    output logic o_tx_mux_ready,
    output pml_pkg::pml_link_s o_link,
    input wire pml_pkg::pml_link_s i_link,
    output pml_pkg::pml_word_s o_rx_tlp,
    output pml_pkg::pml_word_s o_rx_dllp,
    output pml_pkg::pml_mux_rx_s o_rx_mux,
    output logic [NUM_CHAN-1:0] o_chan_active
);
    typedef enum logic [2:0] {
        TX_IDLE, TX_TLP, TX_DLLP, TX_MHEAD, TX_MDATA, TX_MCRC, TX_MDROP
    } pml_tx_e;

    typedef enum logic [1:0] {
        RX_IDLE, RX_TAKE, RX_DROP
    } pml_rx_e;

    typedef struct packed {
        pml_tx_e tx_st;
        logic rdy_tlp;
        logic rdy_dllp;
        logic rdy_mux;
        pml_pkg::pml_link_s link;
        logic [NUM_CHAN-1:0] chan_on;
        logic [NUM_CHAN-1:0] chan_en_q;
        pml_rx_e rx_st;
        logic [pml_pkg::CHAN_W-1:0] rx_chan;
        logic [pml_pkg::META_W-1:0] rx_meta;
        logic [pml_pkg::DATA_W-1:0] pend;
        logic pend_v;
        logic first;
        pml_pkg::pml_word_s rx_tlp;
        pml_pkg::pml_word_s rx_dllp;
        pml_pkg::pml_mux_rx_s rx_mux;
    } pml_st_s;

    pml_st_s st;
    pml_st_s next_st;

    logic [2:0] grant;
    logic arb_take;
    logic mux_ok;
    logic [31:0] hdr;
    logic [31:0] tx_crc;
    logic [31:0] rx_crc;
    logic tx_crc_init;
    logic tx_crc_en;
    logic [31:0] tx_crc_data;
    logic rx_mux_word;
    logic rx_hdr_ok;
    logic rx_crc_init;
    logic rx_crc_en;
    logic kill;

    // Channel field of a mux header word
    function automatic logic [pml_pkg::CHAN_W-1:0] hdr_chan(
        input logic [31:0] w);
        return w[pml_pkg::HDR_CHAN_LSB +: pml_pkg::CHAN_W];
    endfunction

    // Scheduler over TLP, DLLP and mux queues; policy is round robin
    assign arb_take = (st.tx_st == TX_IDLE);
    pml_arb #(
        .N(3)
    ) u_arb (
        .i_mclk(i_mclk),
        .i_srst(i_srst),
        .i_req({i_tx_mux.valid, i_tx_dllp.valid, i_tx_tlp.valid}),
        .i_take(arb_take),
        .o_grant(grant)
    );

    // Header carries metadata where a TLP holds its sequence number
    always_comb begin
        hdr = pml_pkg::WORD_ZERO;
        hdr[pml_pkg::HDR_META_LSB +: pml_pkg::META_W] = i_tx_mux.meta;
        hdr[pml_pkg::HDR_CHAN_LSB +: pml_pkg::CHAN_W] = i_tx_mux.chan;
    end

    assign mux_ok = i_mux_enable && i_tx_mux.sop &&
                    st.chan_on[i_tx_mux.chan];
    assign tx_crc_init = (st.tx_st == TX_MHEAD) && mux_ok;
    assign tx_crc_en = tx_crc_init ||
                       ((st.tx_st == TX_MDATA) && i_tx_mux.valid);
    assign tx_crc_data = tx_crc_init ? hdr : i_tx_mux.data;

    // Distinct seed keeps mux packets from passing a native CRC check
    pml_crc u_tx_crc (
        .i_mclk(i_mclk),
        .i_srst(i_srst),
        .i_init(tx_crc_init),
        .i_en(tx_crc_en),
        .i_seed(MUX_SEED),
        .i_data(tx_crc_data),
        .o_crc(tx_crc)
    );

    assign rx_mux_word = i_link.valid &&
                         (i_link.kind == pml_pkg::PML_KIND_MUX);
    assign rx_hdr_ok = rx_mux_word && i_link.sop && !i_link.eop &&
                       i_mux_enable && st.chan_on[hdr_chan(i_link.data)];
    assign rx_crc_init = rx_hdr_ok;
    assign rx_crc_en = rx_hdr_ok || (rx_mux_word && !i_link.sop &&
                       !i_link.eop && (st.rx_st == RX_TAKE));

    pml_crc u_rx_crc (
        .i_mclk(i_mclk),
        .i_srst(i_srst),
        .i_init(rx_crc_init),
        .i_en(rx_crc_en),
        .i_seed(MUX_SEED),
        .i_data(i_link.data),
        .o_crc(rx_crc)
    );

    assign kill = i_dl_down || !i_speed_supported || !i_mux_enable ||
                  (IS_UPSTREAM && i_flr && (i_flr_func == pml_pkg::FLR_FUNC0));

    always_comb begin
        next_st = st;
        // Channel enables; a channel opens on a rising software enable
        next_st.chan_en_q = i_chan_enable;
        if (kill) begin
            next_st.chan_on = pml_pkg::CHAN_OFF;
        end else begin
            next_st.chan_on = (st.chan_on | (i_chan_enable & ~st.chan_en_q))
                              & i_chan_enable;
        end

        // Transmit: one Link word per cycle, whole packets at a time
        next_st.link.valid = 1'b0;
        unique case (st.tx_st)
            TX_IDLE: begin
                if (grant[0]) begin
                    next_st.tx_st = TX_TLP;
                end else if (grant[1]) begin
                    next_st.tx_st = TX_DLLP;
                end else if (grant[2]) begin
                    next_st.tx_st = TX_MHEAD;
                end
            end
            TX_TLP: begin
                if (i_tx_tlp.valid) begin
                    next_st.link = {1'b1, i_tx_tlp.sop, i_tx_tlp.eop,
                                    pml_pkg::PML_KIND_TLP,
                                    i_tx_tlp.data};
                    if (i_tx_tlp.eop) begin
                        next_st.tx_st = TX_IDLE;
                    end
                end
            end
            TX_DLLP: begin
                if (i_tx_dllp.valid) begin
                    next_st.link = {1'b1, i_tx_dllp.sop, i_tx_dllp.eop,
                                    pml_pkg::PML_KIND_DLLP,
                                    i_tx_dllp.data};
                    if (i_tx_dllp.eop) begin
                        next_st.tx_st = TX_IDLE;
                    end
                end
            end
            TX_MHEAD: begin
                if (mux_ok) begin
                    next_st.link = {1'b1, 1'b1, 1'b0,
                                    pml_pkg::PML_KIND_MUX, hdr};
                    next_st.tx_st = TX_MDATA;
                end else begin
                    next_st.tx_st = TX_MDROP;
                end
            end
            TX_MDATA: begin
                if (i_tx_mux.valid) begin
                    next_st.link = {1'b1, 1'b0, 1'b0,
                                    pml_pkg::PML_KIND_MUX, i_tx_mux.data};
                    if (i_tx_mux.eop) begin
                        next_st.tx_st = TX_MCRC;
                    end
                end
            end
            TX_MCRC: begin
                // Fire and forget: nothing retained for retry
                next_st.link = {1'b1, 1'b0, 1'b1,
                                pml_pkg::PML_KIND_MUX, tx_crc};
                next_st.tx_st = TX_IDLE;
            end
            TX_MDROP: begin
                if (i_tx_mux.valid && i_tx_mux.eop) begin
                    next_st.tx_st = TX_IDLE;
                end
            end
        endcase
        next_st.rdy_tlp = (next_st.tx_st == TX_TLP);
        next_st.rdy_dllp = (next_st.tx_st == TX_DLLP);
        next_st.rdy_mux = (next_st.tx_st == TX_MDATA) ||
                          (next_st.tx_st == TX_MDROP);

        // Receive: classify by framing mark and steer to its queue
        next_st.rx_tlp.valid = 1'b0;
        next_st.rx_dllp.valid = 1'b0;
        next_st.rx_mux.valid = 1'b0;
        if (i_link.valid && (i_link.kind == pml_pkg::PML_KIND_TLP)) begin
            next_st.rx_tlp = {1'b1, i_link.sop, i_link.eop,
                              i_link.data};
        end
        if (i_link.valid && (i_link.kind == pml_pkg::PML_KIND_DLLP)) begin
            next_st.rx_dllp = {1'b1, i_link.sop, i_link.eop, i_link.data};
        end
        if (rx_mux_word) begin
            if (i_link.sop) begin
                if (rx_hdr_ok) begin
                    next_st.rx_st = RX_TAKE;
                    next_st.rx_chan = hdr_chan(i_link.data);
                    next_st.rx_meta = i_link.data[pml_pkg::HDR_META_LSB +:
                                                  pml_pkg::META_W];
                    next_st.pend_v = 1'b0;
                    next_st.first = 1'b1;
                end else begin
                    next_st.rx_st = i_link.eop ? RX_IDLE : RX_DROP;
                end
            end else if (st.rx_st == RX_TAKE) begin
                // Last word is the CRC; payload lags one word behind
                next_st.rx_mux.chan = st.rx_chan;
                next_st.rx_mux.proto = i_chan_proto[st.rx_chan];
                next_st.rx_mux.meta = st.rx_meta;
                next_st.rx_mux.data = st.pend;
                next_st.rx_mux.sop = st.first;
                next_st.rx_mux.eop = i_link.eop;
                next_st.rx_mux.crc_err = i_link.eop &&
                                         (i_link.data != rx_crc);
                next_st.rx_mux.valid = st.pend_v;
                if (st.pend_v) begin
                    next_st.first = 1'b0;
                end
                if (i_link.eop) begin
                    next_st.rx_st = RX_IDLE;
                    next_st.pend_v = 1'b0;
                end else begin
                    next_st.pend = i_link.data;
                    next_st.pend_v = 1'b1;
                end
            end else if (i_link.eop) begin
                next_st.rx_st = RX_IDLE;
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_tx_tlp_ready = st.rdy_tlp;
    assign o_tx_dllp_ready = st.rdy_dllp;
    assign o_tx_mux_ready = st.rdy_mux;
    assign o_link = st.link;
    assign o_rx_tlp = st.rx_tlp;
    assign o_rx_dllp = st.rx_dllp;
    assign o_rx_mux = st.rx_mux;
    assign o_chan_active = st.chan_on;

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_srst);

    property p_no_tx_off;
        (o_link.valid && o_link.kind == pml_pkg::PML_KIND_MUX && o_link.sop)
            |-> $past(i_mux_enable);
    endproperty
    a_no_tx_off: assert property (p_no_tx_off)
        else $error("mux packet sent while disabled");

    property p_rx_off;
        (rx_mux_word && i_link.sop && !i_mux_enable)
            |=> (st.rx_st != RX_TAKE) ##1 !o_rx_mux.valid;
    endproperty
    a_rx_off: assert property (p_rx_off)
        else $error("mux packet accepted while disabled");

    property p_tlp_pass;
        (st.tx_st == TX_TLP && i_tx_tlp.valid) |=> o_link.valid &&
            o_link.kind == pml_pkg::PML_KIND_TLP &&
            o_link.data == $past(i_tx_tlp.data);
    endproperty
    a_tlp_pass: assert property (p_tlp_pass)
        else $error("TLP word altered on the Link");

    property p_crc_tail;
        (o_link.valid && o_link.kind == pml_pkg::PML_KIND_MUX && o_link.eop)
            |-> o_link.data == tx_crc && $past(st.tx_st) == TX_MCRC;
    endproperty
    a_crc_tail: assert property (p_crc_tail)
        else $error("mux packet tail is not its CRC");

    property p_meta;
        (st.tx_st == TX_MHEAD && mux_ok) |=> o_link.valid && o_link.sop &&
            o_link.kind == pml_pkg::PML_KIND_MUX &&
            o_link.data[pml_pkg::HDR_META_LSB +: pml_pkg::META_W] ==
            $past(i_tx_mux.meta) && st.tx_st == TX_MDATA;
    endproperty
    a_meta: assert property (p_meta)
        else $error("metadata missing from mux header");

    property p_speed;
        !i_speed_supported |=> o_chan_active == pml_pkg::CHAN_OFF;
    endproperty
    a_speed: assert property (p_speed)
        else $error("channel active at unsupported speed");

    property p_flr0;
        (IS_UPSTREAM && i_flr && i_flr_func == pml_pkg::FLR_FUNC0)
            |=> o_chan_active == pml_pkg::CHAN_OFF;
    endproperty
    a_flr0: assert property (p_flr0)
        else $error("channel survived FLR to function 0");

    property p_drop;
        (st.tx_st == TX_MHEAD && !st.chan_on[i_tx_mux.chan])
            |=> st.tx_st == TX_MDROP && !o_link.valid;
    endproperty
    a_drop: assert property (p_drop)
        else $error("request for disabled channel not dropped");
endmodule
`default_nettype wire

/* inc/pml_pkg.sv */
// Shared constants and carrier types for the protocol multiplex link layer
package pml_pkg;
    localparam int NUM_CHAN = 4;
    localparam int CHAN_W = 2;
    localparam int META_W = 12;
    localparam int PROTO_W = 8;
    localparam int DATA_W = 32;
    localparam int FUNC_W = 8;
    // Header word layout of a mux packet
    localparam int HDR_META_LSB = 0;
    localparam int HDR_CHAN_LSB = 12;
    // CRC-32 generator shared with the native link CRC
    localparam logic [31:0] CRC_POLY = 32'h04C1_1DB7;
    // Native packet seed, kept for reference only; mux seed must differ
    localparam logic [31:0] TLP_SEED = 32'hFFFF_FFFF;
    localparam logic [31:0] MUX_SEED = 32'h5A5A_A5A5;
    localparam logic [FUNC_W-1:0] FLR_FUNC0 = 8'h00;
    localparam logic [NUM_CHAN-1:0] CHAN_OFF = 4'h0;
    localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        PML_KIND_TLP,
        PML_KIND_DLLP,
        PML_KIND_MUX
    } pml_kind_e;

    typedef struct packed {
        logic valid;
        logic sop;
        logic eop;
        logic [DATA_W-1:0] data;
    } pml_word_s;

    typedef struct packed {
        logic valid;
        logic sop;
        logic eop;
        pml_kind_e kind;
        logic [DATA_W-1:0] data;
    } pml_link_s;

    typedef struct packed {
        logic valid;
        logic sop;
        logic eop;
        logic [CHAN_W-1:0] chan;
        logic [META_W-1:0] meta;
        logic [DATA_W-1:0] data;
    } pml_mux_tx_s;

    typedef struct packed {
        logic valid;
        logic sop;
        logic eop;
        logic crc_err;
        logic [CHAN_W-1:0] chan;
        logic [PROTO_W-1:0] proto;
        logic [META_W-1:0] meta;
        logic [DATA_W-1:0] data;
    } pml_mux_rx_s;
endpackage

/* rtl/pml_crc.sv */
// Word-wide CRC-32 accumulator with loadable seed
`timescale 1ns/10ps
`default_nettype none
module pml_crc (
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic i_init,
    input wire logic i_en,
    input wire logic [31:0] i_seed,
    input wire logic [31:0] i_data,
    output logic [31:0] o_crc
);
    typedef struct packed {
        logic [31:0] crc;
    } pml_crc_st_s;

    pml_crc_st_s st;
    pml_crc_st_s next_st;

    function automatic logic [31:0] crc_step(input logic [31:0] c,
                                             input logic [31:0] d);
        logic [31:0] r;
        logic fb;
        r = c;
        for (int i = 31; i >= 0; i--) begin
            fb = r[31] ^ d[i];
            r = {r[30:0], 1'b0} ^ (fb ? pml_pkg::CRC_POLY : 32'h0000_0000);
        end
        return r;
    endfunction

    always_comb begin
        logic [31:0] base;
        base = i_init ? i_seed : st.crc;
        next_st = st;
        if (i_en) begin
            next_st.crc = crc_step(base, i_data);
        end else if (i_init) begin
            next_st.crc = i_seed;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_crc = st.crc;
endmodule
`default_nettype wire

/* rtl/pml_arb.sv */
// Round-robin scheduler among transmit queues
`timescale 1ns/10ps
`default_nettype none
module pml_arb #(
    parameter int N = 3
) (
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic [N-1:0] i_req,
    input wire logic i_take,
    output logic [N-1:0] o_grant
);
    localparam int IW = (N > 1) ? $clog2(N) : 1;

    typedef struct packed {
        logic [IW-1:0] last;
    } pml_arb_st_s;

    pml_arb_st_s st;
    pml_arb_st_s next_st;

    // Search starts just past the last winner so no queue starves
    always_comb begin
        int idx;
        logic found;
        idx = 0;
        found = 1'b0;
        o_grant = '0;
        next_st = st;
        for (int k = 1; k <= N; k++) begin
            idx = int'(st.last) + k;
            if (idx >= N) begin
                idx = idx - N;
            end
            if (!found && i_req[idx]) begin
                found = 1'b1;
                o_grant[idx] = 1'b1;
                if (i_take) begin
                    next_st.last = IW'(idx);
                end
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule
`default_nettype wire

/* tb/pml_peer.sv */
// Peer port model at the far end of the Link
`timescale 1ns/10ps
`default_nettype none
module pml_peer #(
    parameter logic [31:0] SEED = pml_pkg::MUX_SEED
) (
    input wire logic i_mclk,
    input wire pml_pkg::pml_link_s i_link,
    output pml_pkg::pml_link_s o_link
);
    pml_pkg::pml_link_s rxq[$];
    initial o_link = '0;
    always @(posedge i_mclk) begin
        if (i_link.valid === 1'b1) begin
            rxq.push_back(i_link);
        end
    end
    // MSB first, no final inversion
    function automatic logic [31:0] crc(logic [31:0] c, logic [31:0] d);
        for (int i = 31; i >= 0; i--) begin
            c = (c[31] ^ d[i]) ? ((c << 1) ^ pml_pkg::CRC_POLY)
                               : (c << 1);
        end
        return c;
    endfunction
    task automatic send(pml_pkg::pml_kind_e k, logic s, logic e,
        logic [31:0] d);
        @(posedge i_mclk);
        o_link <= '{valid: 1'b1, sop: s, eop: e, kind: k, data: d};
    endtask
    // Released line shows inverted data
    task automatic idle();
        @(posedge i_mclk);
        o_link <= '{1'b0, 1'b0, 1'b0, o_link.kind, ~o_link.data};
    endtask
    task automatic send_mux(logic [1:0] ch, logic [11:0] m,
        logic [31:0] d, logic bad);
        logic [31:0] h;
        h = {18'h0_0000, ch, m};
        send(pml_pkg::PML_KIND_MUX, 1'b1, 1'b0, h);
        send(pml_pkg::PML_KIND_MUX, 1'b0, 1'b0, d);
        send(pml_pkg::PML_KIND_MUX, 1'b0, 1'b1,
            crc(crc(SEED, h), d) ^ {31'h0000_0000, bad});
        idle();
    endtask
endmodule
`default_nettype wire

/* tb/test_protocol_mux_link_layer.sv */
// Self-checking bench for the protocol multiplex link layer
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module test_protocol_mux_link_layer;
    logic i_mclk = 1'b0;
    logic i_srst = 1'b1;
    logic mux_en = 1'b0;
    logic [3:0] chen = 4'h0;
    logic [3:0][7:0] proto = '0;
    logic spd = 1'b1;
    logic flr = 1'b0;
    logic [7:0] flr_func = 8'h00;
    pml_pkg::pml_word_s tlp = '0;
    pml_pkg::pml_word_s dllp = '0;
    pml_pkg::pml_mux_tx_s mux = '0;
    logic tlp_rdy, dllp_rdy, mux_rdy;
    logic [3:0] active;
    pml_pkg::pml_link_s lnk_out, lnk_in;
    pml_pkg::pml_word_s rx_tlp, rx_dllp;
    pml_pkg::pml_mux_rx_s rx_mux;
    pml_pkg::pml_mux_rx_s muxq[$];
    pml_pkg::pml_word_s tlpq[$];
    pml_pkg::pml_word_s dllpq[$];
    int err_total = 0;
    int tests_run = 0;

    always #10 i_mclk = ~i_mclk;

    pml_link dut_u (.i_mclk(i_mclk), .i_srst(i_srst),
        .i_mux_enable(mux_en), .i_chan_enable(chen),
        .i_chan_proto(proto), .i_speed_supported(spd),
        .i_dl_down(1'b0), .i_flr(flr), .i_flr_func(flr_func),
        .i_tx_tlp(tlp), .o_tx_tlp_ready(tlp_rdy),
        .i_tx_dllp(dllp), .o_tx_dllp_ready(dllp_rdy),
        .i_tx_mux(mux), .o_tx_mux_ready(mux_rdy),
        .o_link(lnk_out), .i_link(lnk_in), .o_rx_tlp(rx_tlp),
        .o_rx_dllp(rx_dllp), .o_rx_mux(rx_mux), .o_chan_active(active));
    pml_peer peer_u (.i_mclk(i_mclk), .i_link(lnk_out), .o_link(lnk_in));

    always @(posedge i_mclk) begin
        if (rx_mux.valid === 1'b1) muxq.push_back(rx_mux);
        if (rx_tlp.valid === 1'b1) tlpq.push_back(rx_tlp);
        if (rx_dllp.valid === 1'b1) dllpq.push_back(rx_dllp);
    end

    task automatic stop_test();
        if (err_total == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic settle();
        repeat (12) @(posedge i_mclk);
    endtask
    // One-word packet from an upper queue: 0 native, 1 link, 2 mux
    task automatic tx(int k, logic [1:0] ch, logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_mclk);
        if (k == 0) tlp <= '{1'b1, 1'b1, 1'b1, d};
        else if (k == 1) dllp <= '{1'b1, 1'b1, 1'b1, d};
        else mux <= '{1'b1, 1'b1, 1'b1, ch, {d[9:0], ch}, d};
        do @(posedge i_mclk);
        while ((k == 0 ? tlp_rdy : k == 1 ? dllp_rdy : mux_rdy) !== 1'b1
            && ++n < 50);
        `CHK(n < 50, 1'b1)
        if (k == 0) tlp <= '0;
        else if (k == 1) dllp <= '0;
        else mux <= '0;
    endtask
    task automatic chk_mux(int i, logic [1:0] ch, logic [31:0] d);
        logic [31:0] h;
        h = {18'h0_0000, ch, d[9:0], ch};
        `CHK(peer_u.rxq[i].kind, pml_pkg::PML_KIND_MUX)
        `CHK({peer_u.rxq[i].sop, peer_u.rxq[i].data}, {1'b1, h})
        `CHK(peer_u.rxq[i+1].data, d)
        `CHK({peer_u.rxq[i+2].eop, peer_u.rxq[i+2].data},
            {1'b1, peer_u.crc(peer_u.crc(pml_pkg::MUX_SEED, h), d)})
    endtask
    task automatic chan_on(logic [3:0] m);
        @(posedge i_mclk);
        chen <= 4'h0;
        @(posedge i_mclk);
        chen <= m;
        repeat (3) @(posedge i_mclk);
    endtask
    task automatic flr_hit(logic [7:0] f);
        @(posedge i_mclk);
        flr <= 1'b1;
        flr_func <= f;
        @(posedge i_mclk);
        flr <= 1'b0;
        repeat (3) @(posedge i_mclk);
    endtask

    task automatic t_reset();
        repeat (2) @(posedge i_mclk);
        `CHK({active, lnk_out.valid, mux_rdy}, 6'h00)
    endtask
    task automatic t_disabled();
        chan_on(4'hF);
        `CHK(active, 4'h0)
        tx(2, 2'd1, 32'h0BAD_0001);
        settle();
        `CHK(peer_u.rxq.size(), 0)
        peer_u.send_mux(2'd1, 12'h123, 32'h0BAD_0002, 1'b0);
        settle();
        `CHK(muxq.size(), 0)
    endtask
    task automatic t_tx_mux();
        mux_en <= 1'b1;
        chan_on(4'hF);
        `CHK(active, 4'hF)
        tx(2, 2'd3, 32'hFFFF_0FFF);
        settle();
        `CHK(peer_u.rxq.size(), 3)
        chk_mux(0, 2'd3, 32'hFFFF_0FFF);
    endtask
    task automatic t_mix();
        logic [2:0] seen;
        seen = 3'b000;
        peer_u.rxq.delete();
        fork
            tx(0, 2'd0, 32'h1234_5678);
            tx(1, 2'd0, 32'hDDDD_0000);
            tx(2, 2'd0, 32'h8000_0155);
        join
        settle();
        `CHK(peer_u.rxq.size(), 5)
        foreach (peer_u.rxq[i]) begin
            if (peer_u.rxq[i].kind == pml_pkg::PML_KIND_TLP) begin
                seen[0] = 1'b1;
                `CHK(peer_u.rxq[i].data, 32'h1234_5678)
            end else if (peer_u.rxq[i].kind == pml_pkg::PML_KIND_DLLP) begin
                seen[1] = 1'b1;
                `CHK(peer_u.rxq[i].data, 32'hDDDD_0000)
            end else if (peer_u.rxq[i].sop === 1'b1) begin
                seen[2] = 1'b1;
                chk_mux(i, 2'd0, 32'h8000_0155);
            end
        end
        `CHK(seen, 3'b111)
    endtask
    task automatic t_rx();
        proto <= {8'h44, 8'h33, 8'h22, 8'h11};
        peer_u.send_mux(2'd2, 12'hABC, 32'hC0DE_0002, 1'b0);
        peer_u.send(pml_pkg::PML_KIND_TLP, 1'b1, 1'b1, 32'h7777_0000);
        peer_u.send(pml_pkg::PML_KIND_DLLP, 1'b1, 1'b1, 32'h6666_0000);
        peer_u.idle();
        settle();
        `CHK(muxq.size(), 1)
        `CHK({muxq[0].sop, muxq[0].eop, muxq[0].crc_err, muxq[0].chan,
            muxq[0].proto, muxq[0].meta, muxq[0].data},
            {3'b110, 2'd2, 8'h33, 12'hABC, 32'hC0DE_0002})
        `CHK(tlpq[0].data, 32'h7777_0000)
        `CHK(dllpq[0].data, 32'h6666_0000)
        muxq.delete();
        peer_u.send_mux(2'd2, 12'h001, 32'hC0DE_0003, 1'b1);
        settle();
        `CHK(muxq[0].crc_err, 1'b1)
    endtask
    task automatic t_kill();
        flr_hit(8'h01);
        `CHK(active, 4'hF)
        flr_hit(8'h00);
        `CHK(active, 4'h0)
        chan_on(4'hF);
        spd <= 1'b0;
        repeat (3) @(posedge i_mclk);
        `CHK(active, 4'h0)
        spd <= 1'b1;
        chan_on(4'h1);
        peer_u.rxq.delete();
        tx(2, 2'd1, 32'h0BAD_0003);
        tx(2, 2'd0, 32'h0000_0ABC);
        settle();
        `CHK(peer_u.rxq.size(), 3)
        chk_mux(0, 2'd0, 32'h0000_0ABC);
    endtask

    initial begin
        repeat (20) @(posedge i_mclk);
        i_srst <= 1'b0;
        t_reset();
        t_disabled();
        t_tx_mux();
        t_mix();
        t_rx();
        t_kill();
        stop_test();
    end
    initial begin
        #400000;
        err_total++;
        stop_test();
    end
endmodule
`default_nettype wire
